// *** aas_supervisor.v ***
/*
 * amplifier alarm supervisor: compares measurement codes against trip
 * and clear thresholds, drives the rf disable and bias removal, the
 * yellow indicator, an event strobe fed by 16 pending code bits and ttl/serial alarm lines.
 * assumes measurements are synchronous codes from the adc front end and
 * that the subrack samples the ttl lines and the serial frame line.
 */
`include "aas_consts.vh"
module aas_supervisor #(
	// 34 bits wide, so the minute-long counts do not wrap at 32 bits
	parameter [33:0] REV_QUAL_CYC = 34'd1 * `AAS_REV_QUAL_S * `AAS_CYC_PER_S, // one minute
	parameter [33:0] LOOP_TRY_CYC = 34'd1 * `AAS_LOOP_TRY_S * `AAS_CYC_PER_S, // 2 min 5 s
	parameter SER_DIV = 16'd868 // serial bit period in clocks
) (
	// clock and reset
	input wire core_clk_i,
	input wire rstn_i,
	// measurements, same clock domain
	input wire [15:0] out_pwr_i,
	input wire [15:0] in_pwr_i,
	input wire [15:0] temp_i,
	input wire [15:0] rev_pwr_i,
	input wire [15:0] supply_i,
	// status pins from other blocks, asynchronous
	input wire rail_ok_i,
	input wire device_fail_i,
	input wire loop_over_range_i,
	input wire man_reset_i,
	// rf control
	output reg rf_disable_o,
	output reg bias_5v_en_o,
	output reg limit_en_o,
	output reg yellow_led_o,
	// alarm report
	output reg major_ttl_o,
	output reg minor_ttl_o,
	output reg perm_shutdown_o,
	output reg ser_tx_o,
	// event log strobe
	output reg log_valid_o,
	output reg [3:0] log_code_o
);

	// fsm states for the loop retry sequence
	localparam LP_OK = 2'd0;
	localparam LP_WAIT = 2'd1;
	localparam LP_DEAD = 2'd2;

	// two-flop synchronisers for pin inputs
	reg [3:0] sync_a;
	reg [3:0] sync_b;
	wire rail_ok = sync_b[0];
	wire dev_fail = sync_b[1];
	wire loop_bad = sync_b[2];
	wire man_reset = sync_b[3];
	reg man_reset_d; // edge detect so a held button acts once
	wire man_pulse = man_reset && !man_reset_d;

	always @(posedge core_clk_i) begin
		if (!rstn_i) begin
			sync_a <= 4'h1; // rail-ok bit rests at its idle level: no false rail alarm
			sync_b <= 4'h1;
			man_reset_d <= 1'b0;
		end else begin
			sync_a <= {man_reset_i, loop_over_range_i, device_fail_i, rail_ok_i};
			sync_b <= sync_a;
			man_reset_d <= man_reset;
		end
	end

	// threshold compares
	wire op_trip = out_pwr_i > (`AAS_OUT_RATED + `AAS_OUT_TRIP_DB10);
	wire op_clr = out_pwr_i < (`AAS_OUT_RATED + `AAS_OUT_TRIP_DB10);
	wire lim_trip = out_pwr_i > `AAS_OUT_LIMIT;
	wire lim_clr = out_pwr_i < `AAS_OUT_RATED;
	wire od_trip = in_pwr_i > `AAS_IN_TRIP;
	wire od_clr = in_pwr_i < `AAS_IN_CLEAR;
	wire tp_trip = temp_i > `AAS_TEMP_TRIP;
	wire tp_clr = temp_i < `AAS_TEMP_CLEAR;
	wire rv_high = rev_pwr_i > `AAS_REV_TRIP;
	wire rv_clr = rev_pwr_i < `AAS_REV_CLEAR;
	wire vh_trip = supply_i > `AAS_VHI_TRIP;
	wire vh_clr = supply_i < `AAS_VHI_CLEAR;
	wire vl_trip = supply_i < `AAS_VLO_TRIP;
	wire vl_clr = supply_i > `AAS_VLO_CLEAR;

	// reflected power qualification counter
	reg [33:0] rv_cnt;
	reg rv_qual;
	always @(posedge core_clk_i) begin
		if (!rstn_i) begin
			rv_cnt <= 34'h0;
			rv_qual <= 1'b0;
		end else if (!rv_high) begin
			rv_cnt <= 34'h0;
			rv_qual <= 1'b0;
		end else if (rv_cnt >= REV_QUAL_CYC - 1) begin
			rv_qual <= 1'b1;
		end else begin
			rv_cnt <= rv_cnt + 34'h1;
			rv_qual <= 1'b0;
		end
	end

	// alarm cells; latched ones need the manual pulse, except the device cell, which only core reset clears
	wire a_op, a_lim, a_od, a_tp, a_rv, a_vh, a_vl, a_rail, a_dev;
	aas_hyst #(.LATCH(1)) u_op (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
		.trip_i(op_trip), .clear_ok_i(op_clr), .man_reset_i(man_pulse),
		.alarm_o(a_op));
	aas_hyst #(.LATCH(0)) u_lim (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
		.trip_i(lim_trip), .clear_ok_i(lim_clr), .man_reset_i(1'b0),
		.alarm_o(a_lim));
	aas_hyst #(.LATCH(1)) u_od (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
		.trip_i(od_trip), .clear_ok_i(od_clr), .man_reset_i(man_pulse),
		.alarm_o(a_od));
	aas_hyst #(.LATCH(0)) u_tp (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
		.trip_i(tp_trip), .clear_ok_i(tp_clr), .man_reset_i(1'b0),
		.alarm_o(a_tp));
	aas_hyst #(.LATCH(1)) u_rv (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
		.trip_i(rv_qual), .clear_ok_i(rv_clr), .man_reset_i(man_pulse),
		.alarm_o(a_rv));
	aas_hyst #(.LATCH(0)) u_vh (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
		.trip_i(vh_trip), .clear_ok_i(vh_clr), .man_reset_i(1'b0),
		.alarm_o(a_vh));
	aas_hyst #(.LATCH(0)) u_vl (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
		.trip_i(vl_trip), .clear_ok_i(vl_clr), .man_reset_i(1'b0),
		.alarm_o(a_vl));
	aas_hyst #(.LATCH(0)) u_rail (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
		.trip_i(!rail_ok), .clear_ok_i(rail_ok), .man_reset_i(1'b0),
		.alarm_o(a_rail));
	aas_hyst #(.LATCH(1)) u_dev (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
		.trip_i(dev_fail), .clear_ok_i(1'b0), .man_reset_i(1'b0),
		.alarm_o(a_dev));

	// loop retry machine: each try holds rf off for one try period,
	// then lets the loop attempt convergence; ten failures are final
	reg [1:0] lp_state;
	reg [3:0] lp_tries;
	reg [33:0] lp_cnt;
	reg a_loop;
	reg lp_ev_fail; // one-cycle event flags
	reg lp_ev_rec;
	always @(posedge core_clk_i) begin
		if (!rstn_i) begin
			lp_state <= LP_OK;
			lp_tries <= 4'h0;
			lp_cnt <= 34'h0;
			a_loop <= 1'b0;
			lp_ev_fail <= 1'b0;
			lp_ev_rec <= 1'b0;
		end else begin
			lp_ev_fail <= 1'b0;
			lp_ev_rec <= 1'b0;
			case (lp_state)
				LP_OK: begin
					if (loop_bad) begin
						a_loop <= 1'b1;
						lp_ev_fail <= 1'b1;
						lp_cnt <= 34'h0;
						lp_state <= LP_WAIT;
					end
				end
				LP_WAIT: begin
					if (lp_cnt >= LOOP_TRY_CYC - 1) begin
						lp_cnt <= 34'h0;
						if (!loop_bad) begin
							a_loop <= 1'b0; // loop converged
							lp_ev_rec <= 1'b1;
							lp_tries <= 4'h0;
							lp_state <= LP_OK;
						end else if (lp_tries == `AAS_LOOP_TRIES - 4'h1) begin
							lp_state <= LP_DEAD;
						end else begin
							lp_tries <= lp_tries + 4'h1;
						end
					end else begin
						lp_cnt <= lp_cnt + 34'h1;
					end
				end
				LP_DEAD: begin
					a_loop <= 1'b1; // only core reset leaves this
				end
				default: begin
					lp_state <= LP_OK;
				end
			endcase
		end
	end

	// major and minor summaries; minors never reach the disable path
	wire major = a_op | a_od | a_tp | a_rv | a_vh | a_vl | a_loop;
	wire minor = a_lim | a_rail | a_dev;

	// outputs: all registered
	always @(posedge core_clk_i) begin
		if (!rstn_i) begin
			rf_disable_o <= 1'b1; // rf off in reset; the first clock after it loads major from the cleared alarm cells
			bias_5v_en_o <= 1'b0;
			limit_en_o <= 1'b0;
			yellow_led_o <= 1'b0;
			major_ttl_o <= 1'b0;
			minor_ttl_o <= 1'b0;
			perm_shutdown_o <= 1'b0;
		end else begin
			rf_disable_o <= major;
			bias_5v_en_o <= !major;
			limit_en_o <= a_lim;
			yellow_led_o <= a_lim; // rail and device faults stay dark
			major_ttl_o <= major;
			minor_ttl_o <= minor;
			perm_shutdown_o <= (lp_state == LP_DEAD);
		end
	end

	// event detection: rising and falling edges of each alarm cell; loop events come from the retry machine flags
	reg [8:0] prev;
	wire [8:0] cur = {a_dev, a_rail, a_vl, a_vh, a_rv, a_tp, a_od, a_lim, a_op};
	wire [8:0] rise = cur & ~prev;
	wire [8:0] fall = prev & ~cur;
	reg major_d;
	wire dis_rise = major & ~major_d;
	reg [15:0] pend; // pending event bits, one per code
	reg [15:0] next_pend;
	reg [3:0] pick;

	// first-set pending bit, lowest code first
	function [3:0] aas_first;
		input [15:0] v;
		integer k;
		begin
			aas_first = 4'h0;
			for (k = `AAS_EV_COUNT - 1; k >= 0; k = k - 1) begin
				if (v[k]) begin
					aas_first = k[3:0];
				end
			end
		end
	endfunction

	// gather new events; set wins over the drain of the same bit
	always @* begin
		next_pend = pend;
		pick = aas_first(pend);
		if (pend != 16'h0) begin
			next_pend[pick] = 1'b0;
		end
		if (rise[0]) next_pend[`AAS_EV_OVERPOWER] = 1'b1;
		if (rise[1]) next_pend[`AAS_EV_LIMIT] = 1'b1;
		if (fall[1]) next_pend[`AAS_EV_LIMIT_REC] = 1'b1;
		if (rise[2]) next_pend[`AAS_EV_OVERDRIVE] = 1'b1;
		if (rise[3]) next_pend[`AAS_EV_TEMP] = 1'b1;
		if (fall[3]) next_pend[`AAS_EV_TEMP_REC] = 1'b1;
		if (rise[4]) next_pend[`AAS_EV_REFLECT] = 1'b1;
		if (rise[5]) next_pend[`AAS_EV_VHI] = 1'b1;
		if (rise[6]) next_pend[`AAS_EV_VLO] = 1'b1;
		if (fall[5] | fall[6]) next_pend[`AAS_EV_SUPPLY_REC] = 1'b1;
		if (rise[7]) next_pend[`AAS_EV_RAIL] = 1'b1;
		if (fall[7]) next_pend[`AAS_EV_RAIL_REC] = 1'b1;
		if (rise[8]) next_pend[`AAS_EV_DEVICE] = 1'b1;
		if (lp_ev_fail) next_pend[`AAS_EV_LOOP] = 1'b1;
		if (lp_ev_rec) next_pend[`AAS_EV_LOOP_REC] = 1'b1;
		if (dis_rise) next_pend[`AAS_EV_DISABLE] = 1'b1;
	end

	// log strobe drains one pending event a cycle; disable code 0 wins first
	always @(posedge core_clk_i) begin
		if (!rstn_i) begin
			prev <= 9'h0;
			major_d <= 1'b0;
			pend <= 16'h0;
			log_valid_o <= 1'b0;
			log_code_o <= 4'h0;
		end else begin
			prev <= cur;
			major_d <= major;
			pend <= next_pend;
			log_valid_o <= (pend != 16'h0);
			log_code_o <= (pend != 16'h0) ? pick : 4'h0;
		end
	end

	// serial alarm frame: start 0, 8 data bits lsb first, stop 1,
	// sent whenever the summary changes so the subrack stays in step
	reg [7:0] frame_now;
	reg [7:0] frame_sent;
	reg [9:0] sh;
	reg [3:0] bitn;
	reg [15:0] baud;
	reg busy;
	always @* begin
		frame_now = {perm_shutdown_o, minor_ttl_o, major_ttl_o, a_loop, a_vl | a_vh,
			a_rv, a_tp, a_op | a_od};
	end
	always @(posedge core_clk_i) begin
		if (!rstn_i) begin
			frame_sent <= 8'h0;
			sh <= 10'h3ff;
			bitn <= 4'h0;
			baud <= 16'h0;
			busy <= 1'b0;
			ser_tx_o <= 1'b1;
		end else if (!busy) begin
			ser_tx_o <= 1'b1;
			if (frame_now != frame_sent) begin
				frame_sent <= frame_now;
				sh <= {1'b1, frame_now, 1'b0};
				bitn <= 4'h0;
				baud <= 16'h0;
				busy <= 1'b1;
			end
		end else begin
			ser_tx_o <= sh[0];
			if (baud == SER_DIV - 16'h1) begin
				baud <= 16'h0;
				sh <= {1'b1, sh[9:1]};
				if (bitn == 4'd9) begin
					busy <= 1'b0;
				end else begin
					bitn <= bitn + 4'h1;
				end
			end else begin
				baud <= baud + 16'h1;
			end
		end
	end

endmodule

// *** aas_consts.vh ***
/*
 * constants for the amplifier alarm supervisor: thresholds in raw
 * measurement codes, timing figures, event codes.
 * assumes measurement codes rise monotonically with the physical value
 * and that the measurement chain has already scaled them.
 */
`ifndef AAS_CONSTS_VH
`define AAS_CONSTS_VH

// clock
`define AAS_CLK_MHZ 100
// output power, dbm times 10 (rated max 48.0 dbm, overpower 50.0+)
`define AAS_OUT_RATED 16'd480
`define AAS_OUT_TRIP_DB10 16'd20
`define AAS_OUT_LIMIT 16'd500
// input power, dbm times 10 plus 1000 offset (-6.0 -> 940, -6.6 -> 934)
`define AAS_IN_TRIP 16'd940
`define AAS_IN_CLEAR 16'd934
// temperature, degrees c plus 100 offset
`define AAS_TEMP_TRIP 16'd188
`define AAS_TEMP_CLEAR 16'd173
// reverse power, dbm times 10; clear is 50 percent of rated forward (-3 dB)
`define AAS_REV_TRIP 16'd478
`define AAS_REV_CLEAR 16'd450
// supply, volts times 10
`define AAS_VHI_TRIP 16'd305
`define AAS_VHI_CLEAR 16'd300
`define AAS_VLO_TRIP 16'd205
`define AAS_VLO_CLEAR 16'd240
// timing figures
`define AAS_REV_QUAL_S 60
`define AAS_LOOP_TRY_S 125
`define AAS_LOOP_TRIES 4'd10
`define AAS_CYC_PER_S (`AAS_CLK_MHZ * 1000000)
// event codes
`define AAS_EV_OVERPOWER 4'h1
`define AAS_EV_LIMIT 4'h2
`define AAS_EV_LIMIT_REC 4'h3
`define AAS_EV_OVERDRIVE 4'h4
`define AAS_EV_TEMP 4'h5
`define AAS_EV_TEMP_REC 4'h6
`define AAS_EV_REFLECT 4'h7
`define AAS_EV_VHI 4'h8
`define AAS_EV_VLO 4'h9
`define AAS_EV_SUPPLY_REC 4'ha
`define AAS_EV_LOOP 4'hb
`define AAS_EV_LOOP_REC 4'hc
`define AAS_EV_RAIL 4'hd
`define AAS_EV_RAIL_REC 4'he
`define AAS_EV_DEVICE 4'hf
`define AAS_EV_DISABLE 4'h0
`define AAS_EV_COUNT 16

`endif

// *** aas_hyst.v ***
/*
 * one hysteresis alarm cell: trips on a strobe from the caller, clears
 * itself or on manual reset when the clear condition holds.
 * assumes trip and clear conditions come from the same clock domain.
 */
module aas_hyst #(
	parameter LATCH = 0 // 1: needs manual reset to clear
) (
	// clock and reset
	input wire core_clk_i,
	input wire rstn_i,
	// conditions
	input wire trip_i,
	input wire clear_ok_i,
	input wire man_reset_i,
	// state
	output reg alarm_o
);

	// trip wins over clear so an event in the clear cycle survives
	always @(posedge core_clk_i) begin
		if (!rstn_i) begin
			alarm_o <= 1'b0;
		end else if (trip_i) begin
			alarm_o <= 1'b1;
		end else if (clear_ok_i && (LATCH == 0 || man_reset_i)) begin
			alarm_o <= 1'b0;
		end
	end

endmodule

// *** aas_monitor.sv ***
/*
 * port checker for the amplifier alarm supervisor.
 * assumes one clock and a synchronous active-low reset; bound below.
 */
module aas_monitor (
	// clock and reset
	input wire core_clk_i,
	input wire rstn_i,
	// measurements
	input wire [15:0] out_pwr_i,
	input wire [15:0] in_pwr_i,
	input wire [15:0] temp_i,
	input wire [15:0] supply_i,
	// outputs watched
	input wire rf_disable_o,
	input wire bias_5v_en_o,
	input wire limit_en_o,
	input wire yellow_led_o,
	input wire major_ttl_o,
	input wire log_valid_o,
	input wire [3:0] log_code_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// one domain, so clock and disable are given once
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);

	chk_major_disables: assert property (major_ttl_o |-> rf_disable_o)
		else $error("major alarm without rf disable");
	chk_bias_follows: assert property (bias_5v_en_o != rf_disable_o)
		else $error("bias enable not inverse of rf disable");
	chk_overpower_trip: assert property (out_pwr_i > 16'd500 |-> ##2 rf_disable_o)
		else $error("overpower did not disable");
	chk_limit_trip: assert property (out_pwr_i > 16'd500 |-> ##2 (limit_en_o && yellow_led_o))
		else $error("limiting not engaged");
	chk_limit_clear: assert property ($fell(limit_en_o) |-> $past(out_pwr_i, 2) < 16'd480)
		else $error("limiting cleared above rated power");
	chk_overdrive_trip: assert property (in_pwr_i > 16'd940 |-> ##2 major_ttl_o)
		else $error("overdrive did not trip");
	chk_temp_trip: assert property (temp_i > 16'd188 |-> ##2 rf_disable_o)
		else $error("high temperature did not disable");
	chk_vhi_trip: assert property (supply_i > 16'd305 |-> ##2 rf_disable_o)
		else $error("high supply did not disable");
	chk_vlo_trip: assert property (supply_i < 16'd205 |-> ##2 rf_disable_o)
		else $error("low supply did not disable");
	chk_log_idle: assert property (!log_valid_o |-> log_code_o == 4'h0)
		else $error("event code without strobe");
endmodule

bind aas_supervisor aas_monitor mon (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
	.out_pwr_i(out_pwr_i), .in_pwr_i(in_pwr_i), .temp_i(temp_i), .supply_i(supply_i),
	.rf_disable_o(rf_disable_o), .bias_5v_en_o(bias_5v_en_o), .limit_en_o(limit_en_o),
	.yellow_led_o(yellow_led_o), .major_ttl_o(major_ttl_o), .log_valid_o(log_valid_o),
	.log_code_o(log_code_o));

// *** aas_subrack.sv ***
/*
 * subrack side of the alarm report: decodes 8n1 frames, lsb first.
 * assumes an idle-high serial line clocked from the core clock.
 */
module aas_subrack #(
	parameter int DIV = 8 // bit period in clocks
) (
	// clock and line
	input wire core_clk_i,
	input wire ser_rx_i,
	// last good byte
	output logic [7:0] last_byte_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] shreg; // bits as they arrive

	// sample mid-bit; a bad stop bit drops the frame
	initial begin
		last_byte_o = 8'h00;
		forever begin
			@(negedge ser_rx_i);
			repeat (DIV / 2) @(posedge core_clk_i);
			if (ser_rx_i === 1'b0) begin
				for (int b = 0; b < 8; b++) begin
					repeat (DIV) @(posedge core_clk_i);
					shreg[b] = ser_rx_i;
				end
				repeat (DIV) @(posedge core_clk_i);
				if (ser_rx_i === 1'b1) last_byte_o = shreg;
			end
		end
	end
endmodule

// *** aas_supervisor_bench.sv ***
/*
 * self-checking bench for the amplifier alarm supervisor.
 * assumes short qualification and retry counts set below.
 */
module aas_supervisor_bench;
	timeunit 1ns;
	timeprecision 1ns;
	// stimulus, nominal values
	logic core_clk = 0, rstn = 0, rail_ok = 1, dev_fail = 0, loop_bad = 0, man_rst = 0;
	logic [15:0] out = 16'd450, inp = 16'd900, temp = 16'd130, rev = 16'd400, sup = 16'd270;
	// design outputs
	wire rf_dis, bias_en, lim, led, maj, mino, perm, ser, lv;
	wire [3:0] lc;
	wire [7:0] sub_byte;
	logic [15:0] seen = 16'h0; // event codes observed
	logic [3:0] first_lc = 4'hf; // first code logged after seen clears
	int err_count = 0, checked = 0, seed, i;

	aas_supervisor #(.REV_QUAL_CYC(20), .LOOP_TRY_CYC(20), .SER_DIV(16'd8)) dut (
		.core_clk_i(core_clk), .rstn_i(rstn), .out_pwr_i(out), .in_pwr_i(inp),
		.temp_i(temp), .rev_pwr_i(rev), .supply_i(sup), .rail_ok_i(rail_ok),
		.device_fail_i(dev_fail), .loop_over_range_i(loop_bad), .man_reset_i(man_rst),
		.rf_disable_o(rf_dis), .bias_5v_en_o(bias_en), .limit_en_o(lim),
		.yellow_led_o(led), .major_ttl_o(maj), .minor_ttl_o(mino),
		.perm_shutdown_o(perm), .ser_tx_o(ser), .log_valid_o(lv), .log_code_o(lc));
	aas_subrack #(.DIV(8)) sub (.core_clk_i(core_clk), .ser_rx_i(ser), .last_byte_o(sub_byte));

	// 100 mhz clock
	initial begin
		forever #5 core_clk = ~core_clk;
	end
	// collect event strobes
	always @(posedge core_clk) begin
		if (lv === 1'b1 && seen === 16'h0) first_lc = lc;
		if (lv === 1'b1) seen[lc] = 1'b1;
	end

	// fresh-state trip prediction
	function automatic logic exp_dis(input logic [15:0] o, n, t, s);
		return o > 16'd500 || n > 16'd940 || t > 16'd188 || s > 16'd305 || s < 16'd205;
	endfunction
	task automatic step(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk_word({15'h0, got}, {15'h0, exp});
	endtask
	// pin needs sync plus edge detect, so hold a few cycles
	task automatic man_pulse;
		man_rst = 1;
		step(5);
		man_rst = 0;
		step(4);
	endtask
	task automatic end_test(input string s);
		$display("test %s done", s);
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	// hang guard
	initial begin
		#200000;
		err_count++;
		close_out;
	end

	initial begin
		seed = 64023;
		step(2);
		rstn = 1;
		step(3);
		// random safe measurements never disable
		repeat (30) begin
			out = 16'd300 + 16'({$random(seed)} % 180);
			inp = 16'd800 + 16'({$random(seed)} % 141);
			temp = 16'd100 + 16'({$random(seed)} % 73);
			sup = 16'd205 + 16'({$random(seed)} % 101);
			step(3);
			chk_bit(rf_dis, exp_dis(out, inp, temp, sup));
		end
		out = 16'd450; inp = 16'd900; temp = 16'd130; sup = 16'd270;
		end_test("random");
		out = 16'd500; step(4);
		chk_bit(rf_dis, 1'b0);
		chk_bit(lim, 1'b0);
		seen = 0; out = 16'd501; step(7);
		chk_bit(bias_en, 1'b0);
		chk_bit(led, 1'b1);
		chk_word(seen & 16'h0007, 16'h0007);
		chk_word({12'h0, first_lc}, 16'h0000);
		man_pulse;
		chk_bit(rf_dis, 1'b1);
		out = 16'd490; man_pulse;
		chk_bit(rf_dis, 1'b0);
		chk_bit(lim, 1'b1);
		out = 16'd479; step(5);
		chk_bit(lim, 1'b0);
		chk_word(seen & 16'h0008, 16'h0008);
		out = 16'd450;
		end_test("output");
		inp = 16'd941; step(4);
		chk_bit(maj, 1'b1);
		inp = 16'd934; man_pulse;
		chk_bit(rf_dis, 1'b1);
		inp = 16'd933; man_pulse;
		chk_bit(rf_dis, 1'b0);
		end_test("input");
		seen = 0; temp = 16'd189; step(300);
		chk_bit(rf_dis, 1'b1);
		chk_word({8'h0, sub_byte}, 16'h0022);
		temp = 16'd173; step(4);
		chk_bit(rf_dis, 1'b1);
		temp = 16'd172; step(6);
		chk_bit(rf_dis, 1'b0);
		chk_word(seen & 16'h0060, 16'h0060);
		temp = 16'd130;
		end_test("temperature");
		rev = 16'd479; step(15); rev = 16'd478; step(1); rev = 16'd479; step(15);
		chk_bit(rf_dis, 1'b0);
		step(10);
		chk_bit(rf_dis, 1'b1);
		rev = 16'd450; man_pulse;
		chk_bit(rf_dis, 1'b1);
		rev = 16'd449; man_pulse;
		chk_bit(rf_dis, 1'b0);
		end_test("reflected");
		// high then low supply: trip, hold at the clear figure, recover
		for (i = 0; i < 2; i++) begin
			seen = 0; sup = i ? 16'd204 : 16'd306; step(4);
			chk_bit(rf_dis, 1'b1);
			sup = i ? 16'd240 : 16'd300; step(4);
			chk_bit(rf_dis, 1'b1);
			sup = i ? 16'd241 : 16'd299; step(6);
			chk_bit(rf_dis, 1'b0);
			chk_word(seen & 16'h0701, i ? 16'h0601 : 16'h0501);
		end
		sup = 16'd270;
		end_test("supply");
		rail_ok = 0; step(6);
		chk_bit(mino, 1'b1);
		chk_bit(rf_dis, 1'b0);
		rail_ok = 1; step(6);
		chk_bit(mino, 1'b0);
		end_test("rail");
		loop_bad = 1; step(8);
		chk_bit(rf_dis, 1'b1);
		loop_bad = 0; step(30);
		chk_bit(rf_dis, 1'b0);
		loop_bad = 1; step(150);
		chk_bit(perm, 1'b0);
		step(100);
		chk_bit(perm, 1'b1);
		end_test("loop");
		seen = 0; dev_fail = 1; step(6); dev_fail = 0; man_pulse;
		chk_bit(mino, 1'b1);
		chk_word(seen & 16'h8000, 16'h8000);
		end_test("device");
		close_out;
	end
endmodule
